/* hdl/led_boost_cfg.svh */
`ifndef LED_BOOST_CFG_SVH
`define LED_BOOST_CFG_SVH
`define CLK_HZ 100000000
`define OSC_HZ 8000000
`define OSC_DIV (`CLK_HZ / `OSC_HZ)
`define SW_FREQ_HZ 500000
`define SW_FREQ_MAX_HZ 2000000
`define SW_PERIOD_RST 8'h0F
`define SW_DUTY_RST 8'h03
`define SW_PERIOD_MIN 8'h03
`define OV_THRESH_RST 10'h333
`define OV_DELAY_RST 24'h7A1200
`define DIM_STEPS 6'h3F
`define DIM_PRESCALE 8'hFF
`define STRAP_SETTLE 8'h40
`define REG_CTRL 12'h000
`define REG_SW_PERIOD 12'h004
`define REG_SW_DUTY 12'h008
`define REG_OV_THRESH 12'h00C
`define REG_OV_DELAY 12'h010
`define REG_STATUS 12'h014
`define REG_IRQ_STAT 12'h018
`define REG_IRQ_MASK 12'h01C
`define REG_VOUT_ADC 12'h020
`define REG_DIM_ADC 12'h024
`define REG_OSC_TUNE 12'h028
`define CTRL_RUN 0
`define CTRL_SPREAD 1
`define IRQ_OV 0
`define IRQ_RESTART 1
`define IRQ_POT 2
`endif

/* hdl/led_boost_pkg.sv */
package led_boost_pkg;
    typedef struct packed {
        logic [7:0] period;
        logic [7:0] duty;
        logic force_high;
    } sw_cfg_t;
    typedef struct packed {
        logic [9:0] vout;
        logic [9:0] dim;
        logic valid;
    } adc_sample_t;
    typedef enum logic [2:0] {ST_DETECT, ST_IDLE, ST_RUN, ST_SHUTDOWN} seq_state_t;
endpackage

/* hdl/switch_clock_gen.sv */
`timescale 1ns/1ps
`include "led_boost_cfg.svh"
module switch_clock_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic osc_tick,
    input wire led_boost_pkg::sw_cfg_t cfg,
    // Output
    output logic clk_out
);
    logic [7:0] cnt_ff;
    logic [7:0] period_ff;
    logic [7:0] duty_ff;
    logic force_ff;
    // Period and duty latched at period end; free-running once set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 8'h00;
            period_ff <= `SW_PERIOD_RST;
            duty_ff <= `SW_DUTY_RST;
            force_ff <= 1'b1;
        end else if (osc_tick) begin
            if (cnt_ff >= period_ff) begin
                cnt_ff <= 8'h00;
                period_ff <= cfg.period;
                duty_ff <= cfg.duty;
                force_ff <= cfg.force_high;
            end else begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end
    // High for duty counts out of period+1; forced high holds controller off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_out <= 1'b1;
        end else begin
            clk_out <= force_ff | cfg.force_high | (cnt_ff < duty_ff);
        end
    end
endmodule

/* hdl/dim_pwm.sv */
`timescale 1ns/1ps
`include "led_boost_cfg.svh"
module dim_pwm (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Timing and level
    input wire logic timer_tick,
    input wire logic [5:0] level,
    // Output
    output logic pwm_out
);
    logic [5:0] step_ff;
    logic [5:0] level_ff;
    // 63-step counter driven by the free-running timer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_ff <= 6'h00;
            level_ff <= 6'h00;
        end else if (timer_tick) begin
            if (step_ff == `DIM_STEPS - 6'h01) begin
                step_ff <= 6'h00;
                level_ff <= level;
            end else begin
                step_ff <= step_ff + 6'h01;
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_out <= 1'b0;
        end else begin
            pwm_out <= (step_ff < level_ff);
        end
    end
endmodule

/* hdl/led_boost_supervisor.sv */
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "led_boost_cfg.svh"
module led_boost_supervisor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // ADC samples
    input wire logic [9:0] vout_sense_in,
    input wire logic [9:0] dim_adc_in,
    input wire logic adc_valid,
    // Dim sense pin
    input wire logic dim_sense_in,
    output logic weak_pullup,
    // Converter pins
    output logic switch_clock_out,
    output logic ref_enable_out,
    // Oscillator tuning and interrupt
    output logic [7:0] osc_tune,
    output logic irq
);
    logic [3:0] osc_div_ff;
    logic osc_tick_ff;
    logic [7:0] timer_ff;
    logic [7:0] prescale_ff;
    logic timer_tick_ff;
    logic [1:0] ctrl_ff;
    logic [7:0] period_ff;
    logic [7:0] duty_ff;
    logic [9:0] thresh_ff;
    logic [23:0] delay_ff;
    logic [23:0] wait_ff;
    logic [7:0] settle_ff;
    logic pot_ff;
    logic [2:0] irq_stat_ff;
    logic [2:0] irq_mask_ff;
    led_boost_pkg::adc_sample_t adc_ff;
    led_boost_pkg::seq_state_t state_ff;
    led_boost_pkg::sw_cfg_t sw_cfg;
    logic [5:0] dim_level;
    logic dim_wave;
    logic sw_clk;
    logic wr_en;
    logic rd_en;
    logic ov_hit;
    logic ev_ov;
    logic ev_restart;
    logic ev_pot;
    logic [2:0] ev_bits;

    // Clamp period to 3 or more, so frequency reaches about 2.08 MHz, above the 2 MHz controller limit
    function automatic logic [7:0] clamp_period(input logic [7:0] p);
        return (p < `SW_PERIOD_MIN) ? `SW_PERIOD_MIN : p;
    endfunction

    function automatic logic [5:0] scale_adc(input logic [9:0] v);
        logic [15:0] prod;
        prod = 16'(v) * 16'(`DIM_STEPS);
        return prod[15:10];
    endfunction

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // Oscillator tick: one per OSC_DIV (12) bus clocks, about 8.33 MHz
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_div_ff <= 4'h0;
            osc_tick_ff <= 1'b0;
        end else begin
            if (osc_div_ff == 4'(`OSC_DIV - 1)) begin
                osc_div_ff <= 4'h0;
                osc_tick_ff <= 1'b1;
            end else begin
                osc_div_ff <= osc_div_ff + 4'h1;
                osc_tick_ff <= 1'b0;
            end
        end
    end

    // Free-running timer with prescaler
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_ff <= 8'h00;
            prescale_ff <= 8'h00;
            timer_tick_ff <= 1'b0;
        end else begin
            timer_ff <= timer_ff + {7'h00, osc_tick_ff};
            timer_tick_ff <= 1'b0;
            if (osc_tick_ff) begin
                if (prescale_ff == `DIM_PRESCALE) begin
                    prescale_ff <= 8'h00;
                    timer_tick_ff <= 1'b1;
                end else begin
                    prescale_ff <= prescale_ff + 8'h01;
                end
            end
        end
    end

    // Control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= 2'b01;
            period_ff <= `SW_PERIOD_RST;
            duty_ff <= `SW_DUTY_RST;
            thresh_ff <= `OV_THRESH_RST;
            delay_ff <= `OV_DELAY_RST;
            irq_mask_ff <= 3'b000;
        end else if (wr_en) begin
            unique case (paddr)
                `REG_CTRL: ctrl_ff <= pwdata[1:0];
                `REG_SW_PERIOD: period_ff <= clamp_period(pwdata[7:0]);
                `REG_SW_DUTY: duty_ff <= pwdata[7:0];
                `REG_OV_THRESH: thresh_ff <= pwdata[9:0];
                `REG_OV_DELAY: delay_ff <= pwdata[23:0];
                `REG_IRQ_MASK: irq_mask_ff <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // ADC sample capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_ff <= '0;
        end else begin
            adc_ff.valid <= adc_valid;
            if (adc_valid) begin
                adc_ff.vout <= vout_sense_in;
                adc_ff.dim <= dim_adc_in;
            end
        end
    end

    assign ov_hit = adc_ff.valid & (adc_ff.vout >= thresh_ff);

    // Sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= led_boost_pkg::ST_DETECT;
            settle_ff <= 8'h00;
            pot_ff <= 1'b0;
            wait_ff <= 24'h000000;
        end else begin
            unique case (state_ff)
                led_boost_pkg::ST_DETECT: begin
                    settle_ff <= settle_ff + 8'h01;
                    if (settle_ff == `STRAP_SETTLE) begin
                        pot_ff <= ~dim_sense_in;
                        state_ff <= led_boost_pkg::ST_IDLE;
                    end
                end
                led_boost_pkg::ST_IDLE: begin
                    if (ctrl_ff[`CTRL_RUN]) begin
                        state_ff <= led_boost_pkg::ST_RUN;
                    end
                end
                led_boost_pkg::ST_RUN: begin
                    if (ov_hit) begin
                        wait_ff <= delay_ff;
                        state_ff <= led_boost_pkg::ST_SHUTDOWN;
                    end else if (!ctrl_ff[`CTRL_RUN]) begin
                        state_ff <= led_boost_pkg::ST_IDLE;
                    end
                end
                led_boost_pkg::ST_SHUTDOWN: begin
                    if (wait_ff == 24'h000000) begin
                        state_ff <= led_boost_pkg::ST_RUN;
                    end else begin
                        wait_ff <= wait_ff - 24'h000001;
                    end
                end
                default: state_ff <= led_boost_pkg::ST_DETECT;
            endcase
        end
    end

    // Waveform configuration
    always_comb begin
        sw_cfg.period = period_ff;
        sw_cfg.duty = duty_ff;
        sw_cfg.force_high = (state_ff != led_boost_pkg::ST_RUN);
    end

    switch_clock_gen u_swclk (
        .pclk(pclk),
        .presetn(presetn),
        .osc_tick(osc_tick_ff),
        .cfg(sw_cfg),
        .clk_out(sw_clk)
    );

    assign dim_level = pot_ff ? scale_adc(adc_ff.dim) : `DIM_STEPS;

    dim_pwm u_dim (
        .pclk(pclk),
        .presetn(presetn),
        .timer_tick(timer_tick_ff),
        .level(dim_level),
        .pwm_out(dim_wave)
    );

    // Pin outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_clock_out <= 1'b1;
            ref_enable_out <= 1'b0;
            weak_pullup <= 1'b1;
            osc_tune <= 8'h00;
        end else begin
            switch_clock_out <= sw_clk;
            weak_pullup <= (state_ff == led_boost_pkg::ST_DETECT);
            if (state_ff != led_boost_pkg::ST_RUN) begin
                ref_enable_out <= 1'b0;
            end else if (pot_ff) begin
                ref_enable_out <= dim_wave;
            end else begin
                ref_enable_out <= 1'b1;
            end
            if (ctrl_ff[`CTRL_SPREAD] && osc_tick_ff) begin
                osc_tune <= timer_ff;
            end
        end
    end

    // Interrupt events
    assign ev_ov = (state_ff == led_boost_pkg::ST_RUN) & ov_hit;
    assign ev_restart = (state_ff == led_boost_pkg::ST_SHUTDOWN) & (wait_ff == 24'h000000);
    assign ev_pot = (state_ff == led_boost_pkg::ST_DETECT) & (settle_ff == `STRAP_SETTLE)
        & ~dim_sense_in;
    assign ev_bits = {ev_pot, ev_restart, ev_ov};

    // Sticky status, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= 3'b000;
        end else begin
            if (wr_en && paddr == `REG_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~pwdata[2:0]) | ev_bits;
            end else begin
                irq_stat_ff <= irq_stat_ff | ev_bits;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_ff & irq_mask_ff);
        end
    end

    // Read path; slave answers in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                unique case (paddr)
                    `REG_CTRL: prdata <= {30'h0, ctrl_ff};
                    `REG_SW_PERIOD: prdata <= {24'h0, period_ff};
                    `REG_SW_DUTY: prdata <= {24'h0, duty_ff};
                    `REG_OV_THRESH: prdata <= {22'h0, thresh_ff};
                    `REG_OV_DELAY: prdata <= {8'h0, delay_ff};
                    `REG_STATUS: prdata <= {27'h0, pot_ff, 1'b0, 3'(state_ff)};
                    `REG_IRQ_STAT: prdata <= {29'h0, irq_stat_ff};
                    `REG_IRQ_MASK: prdata <= {29'h0, irq_mask_ff};
                    `REG_VOUT_ADC: prdata <= {22'h0, adc_ff.vout};
                    `REG_DIM_ADC: prdata <= {22'h0, adc_ff.dim};
                    `REG_OSC_TUNE: prdata <= {24'h0, osc_tune};
                    default: begin
                        prdata <= 32'h00000000;
                        pslverr <= 1'b1;
                    end
                endcase
            end else if (rd_en) begin
                prdata <= prdata;
            end
        end
    end
endmodule

/* tb/led_boost_chk.sv */
`timescale 1ns/1ps
module led_boost_chk (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched ports
    input wire logic [9:0] vout_sense_in,
    input wire logic adc_valid,
    input wire logic dim_sense_in,
    input wire logic weak_pullup,
    input wire logic switch_clock_out,
    input wire logic ref_enable_out
);
    logic [19:0] hi_ff, prd_ff, low_ff;
    logic [7:0] det_ff;
    logic rise_ok_ff;
    wire ov = adc_valid && vout_sense_in >= 10'h333 && !weak_pullup;
    // Lengths of clock phases, reference gaps and time since reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_ff <= 20'h0;
            prd_ff <= 20'h0;
            low_ff <= 20'h0;
            det_ff <= 8'h0;
            rise_ok_ff <= 1'b0;
        end else begin
            hi_ff <= switch_clock_out ? hi_ff + 20'h1 : 20'h0;
            prd_ff <= $rose(switch_clock_out) ? 20'h1 : prd_ff + 20'h1;
            low_ff <= ref_enable_out ? 20'h0 : low_ff + 20'h1;
            det_ff <= (det_ff == 8'hFF) ? det_ff : det_ff + 8'h1;
            rise_ok_ff <= $rose(switch_clock_out) ? ref_enable_out : rise_ok_ff && ref_enable_out;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_clk_held;
        switch_clock_out [*8];
    endsequence
    sequence s_ref_off;
        !ref_enable_out [*8];
    endsequence
    property p_ov_ref;
        ov |-> ##[1:4] s_ref_off;
    endproperty
    a_ov_ref: assert property (p_ov_ref)
        else $error("reference not removed on over-voltage");
    property p_ov_clk;
        ov |-> ##[1:5] s_clk_held;
    endproperty
    a_ov_clk: assert property (p_ov_clk)
        else $error("clock not held high on over-voltage");
    property p_hold;
        $rose(ref_enable_out) && dim_sense_in |-> low_ff >= 20'h3C;
    endproperty
    a_hold: assert property (p_hold)
        else $error("reference back before restart delay");
    property p_clk_high;
        $fell(switch_clock_out) && rise_ok_ff |-> hi_ff == 20'h24;
    endproperty
    a_clk_high: assert property (p_clk_high)
        else $error("clock high time wrong");
    property p_max_freq;
        $rose(switch_clock_out) |-> prd_ff >= 20'h30;
    endproperty
    a_max_freq: assert property (p_max_freq)
        else $error("clock period too short");
    property p_free_run;
        $fell(switch_clock_out) |-> ##[1:200] switch_clock_out;
    endproperty
    a_free_run: assert property (p_free_run)
        else $error("clock stopped");
    property p_ref_on;
        $fell(weak_pullup) && dim_sense_in |-> ##[0:3] ref_enable_out;
    endproperty
    a_ref_on: assert property (p_ref_on)
        else $error("reference not enabled after start");
    property p_det_on;
        det_ff < 8'h3C |-> weak_pullup;
    endproperty
    a_det_on: assert property (p_det_on)
        else $error("pull-up missing in detect");
    property p_det_off;
        det_ff > 8'h46 |-> !weak_pullup;
    endproperty
    a_det_off: assert property (p_det_off)
        else $error("pull-up left on");
endmodule

/* tb/boost_stage_model.sv */
`timescale 1ns/1ps
module boost_stage_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Converter pins
    input wire logic switch_clock_out,
    input wire logic ref_enable_out,
    // Load and pot
    input wire logic open_load,
    input wire logic [9:0] load_code,
    input wire logic [9:0] dim_code,
    // ADC samples
    output logic [9:0] vout_sense_in,
    output logic [9:0] dim_adc_in,
    output logic adc_valid
);
    logic [9:0] volt_ff;
    logic [3:0] smp_ff;
    wire gate_on = ref_enable_out && !switch_clock_out;
    // Open load: output climbs during each on-phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            volt_ff <= 10'h100;
        end else if (!open_load) begin
            volt_ff <= load_code;
        end else if (gate_on && volt_ff != 10'h3FF) begin
            volt_ff <= volt_ff + 10'h1;
        end
    end
    // Sample every 16 cycles, data scrambled between samples
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_ff <= 4'h0;
            adc_valid <= 1'b0;
            vout_sense_in <= 10'h0;
            dim_adc_in <= 10'h0;
        end else begin
            smp_ff <= smp_ff + 4'h1;
            adc_valid <= (smp_ff == 4'hF);
            vout_sense_in <= (smp_ff == 4'hF) ? volt_ff : ~vout_sense_in;
            dim_adc_in <= (smp_ff == 4'hF) ? dim_code : ~dim_adc_in;
        end
    end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, dim_sense_in, open_load, err_seen;
    logic adc_valid, weak_pullup, switch_clock_out, ref_enable_out, irq, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rng;
    logic [9:0] load_code, dim_code, vout_sense_in, dim_adc_in;
    logic [7:0] osc_tune;
    logic [31:0] exp_q[$];
    int n_errors, check_count, c;
    led_boost_supervisor i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vout_sense_in(vout_sense_in), .dim_adc_in(dim_adc_in), .adc_valid(adc_valid),
        .dim_sense_in(dim_sense_in), .weak_pullup(weak_pullup),
        .switch_clock_out(switch_clock_out), .ref_enable_out(ref_enable_out),
        .osc_tune(osc_tune), .irq(irq));
    boost_stage_model i_far (.pclk(pclk), .presetn(presetn),
        .switch_clock_out(switch_clock_out), .ref_enable_out(ref_enable_out),
        .open_load(open_load), .load_code(load_code), .dim_code(dim_code),
        .vout_sense_in(vout_sense_in), .dim_adc_in(dim_adc_in), .adc_valid(adc_valid));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic meas(input int eh, input int ep);
        int hi;
        while (switch_clock_out !== 1'b0) @(posedge pclk);
        while (switch_clock_out !== 1'b1) @(posedge pclk);
        hi = 0;
        while (switch_clock_out === 1'b1) begin
            @(posedge pclk);
            hi++;
        end
        chk("clock high", hi, eh);
        while (switch_clock_out === 1'b0) begin
            @(posedge pclk);
            hi++;
        end
        chk("clock period", hi, ep);
    endtask
    task automatic ref_count(input int ev);
        c = 0;
        repeat (400) begin
            @(posedge pclk);
            c += (ref_enable_out === 1'b1);
        end
        chk("reference level", c, ev);
    endtask
    task automatic rst(input logic strap);
        presetn <= 1'b0;
        dim_sense_in <= strap;
        repeat (10) @(posedge pclk);
        chk("reset outputs", {switch_clock_out, ref_enable_out, weak_pullup, irq, pready}, 32'h14);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (30) @(posedge pclk);
        chk("pullup", weak_pullup, 32'h1);
        repeat (45) @(posedge pclk);
        chk("pullup", weak_pullup, 32'h0);
    endtask
    // Read data watcher
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            chk("prdata", prdata, exp_q.pop_front());
        end
    end
    // Random load level and pot setting
    always @(posedge pclk) begin
        rng <= xs(rng);
        load_code <= rng[9:0] & 10'h2FF;
        dim_code <= dim_sense_in ? rng[19:10] : 10'h000;
    end
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        wrap_up();
    end
    initial begin
        {presetn, psel, penable, pwrite, open_load, err_seen} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        dim_sense_in = 1'b1;
        load_code = 10'h100;
        dim_code = 10'h0;
        rng = 32'h1D;
        n_errors = 0;
        check_count = 0;
        @(posedge pclk);
        rst(1'b1);
        chk("reference on", ref_enable_out, 32'h1);
        rd(12'h014, 32'h2);
        apb(1'b1, 12'h014, 32'hFF);
        rd(12'h014, 32'h2);
        rd(12'h00C, 32'h333);
        rd(12'h010, 32'h7A1200);
        rd(12'h004, 32'hF);
        rd(12'h008, 32'h3);
        rd(12'h0FC, 32'h0);
        chk("slave error", err_seen, 32'h1);
        meas(36, 192);
        apb(1'b1, 12'h010, 32'h40);
        rd(12'h010, 32'h40);
        ref_count(400);
        $display("test startup done");
        open_load <= 1'b1;
        while (ref_enable_out !== 1'b0) @(posedge pclk);
        open_load <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("clock forced", switch_clock_out, 32'h1);
        chk("irq masked", irq, 32'h0);
        rd(12'h018, 32'h1);
        apb(1'b1, 12'h01C, 32'h1);
        @(posedge pclk);
        chk("irq raised", irq, 32'h1);
        c = 0;
        while (ref_enable_out !== 1'b1) begin
            @(posedge pclk);
            c++;
        end
        chk("restart delay", (c > 45 && c < 66), 32'h1);
        rd(12'h018, 32'h3);
        apb(1'b1, 12'h018, 32'h3);
        rd(12'h018, 32'h0);
        chk("irq cleared", irq, 32'h0);
        meas(36, 192);
        $display("test over-voltage done");
        rst(1'b0);
        rd(12'h014, 32'h12);
        rd(12'h018, 32'h4);
        ref_count(0);
        apb(1'b1, 12'h004, 32'h7);
        apb(1'b1, 12'h008, 32'h1);
        meas(12, 96);
        apb(1'b1, 12'h004, 32'h0);
        meas(12, 48);
        apb(1'b1, 12'h000, 32'h3);
        repeat (40) @(posedge pclk);
        c = int'(osc_tune);
        repeat (12) @(posedge pclk);
        chk("tune moves", (osc_tune !== 8'(c)), 32'h1);
        apb(1'b1, 12'h000, 32'h1);
        $display("test pot and reprogram done");
        wrap_up();
    end
endmodule
bind led_boost_supervisor led_boost_chk i_chk (.pclk(pclk), .presetn(presetn),
    .vout_sense_in(vout_sense_in), .adc_valid(adc_valid), .dim_sense_in(dim_sense_in),
    .weak_pullup(weak_pullup), .switch_clock_out(switch_clock_out),
    .ref_enable_out(ref_enable_out));
